// ---- shared/tsbg_map.svh ----
// Purpose: Register offsets, field positions and reset values for the burst gate
// Assumes: AXI4-Lite byte addressing, one 32-bit word per register
// Notes: Definitions only
`ifndef TSBG_MAP_SVH
`define TSBG_MAP_SVH
`define TSBG_OFF_CTRL 4'h0
`define TSBG_OFF_BURST 4'h4
`define TSBG_OFF_RATE 4'h8
`define TSBG_OFF_SWTRIG 4'hc
`define TSBG_OFF_STATUS 4'h0
`define TSBG_OFF_COUNT 4'h4
`define TSBG_OFF_LEFT 4'h8
`define TSBG_BIT_CTL_EN 0
`define TSBG_BIT_XFER_EN 1
`define TSBG_BIT_TRIG_EN 2
`define TSBG_LSB_EDGE 4
`define TSBG_LSB_SRC 8
`define TSBG_BURST_RST 32'h0000_0001
`define TSBG_RATE_RST 32'h0000_0000
`endif

// ---- shared/tsbg_pkg.sv ----
// Purpose: Types shared by the burst gate modules
// Assumes: Nothing
// Notes: Source codes 0..3 are trigger inputs 1..4, 4 is software
`default_nettype none
package tsbg_pkg;
	typedef enum logic [1:0] {TSBG_EDGE_NONE, TSBG_EDGE_RISE, TSBG_EDGE_FALL,
		TSBG_EDGE_BOTH} tsbg_edge_t;
	typedef enum logic [2:0] {TSBG_SRC_IN1, TSBG_SRC_IN2, TSBG_SRC_IN3, TSBG_SRC_IN4,
		TSBG_SRC_SW} tsbg_src_t;
endpackage
`default_nettype wire

// ---- shared/tsbg_trig_if.sv ----
// Purpose: Carries trigger configuration and the event pulse between modules
// Assumes: One clock domain
// Notes: Detector drives fire
`timescale 1ns/1ps
`default_nettype none
interface tsbg_trig_if;
	import tsbg_pkg::*;
	tsbg_src_t src;
	tsbg_edge_t edge_sel;
	logic sw_pulse;
	logic fire;
	modport det (input src, input edge_sel, input sw_pulse, output fire);
	modport ctl (output src, output edge_sel, output sw_pulse, input fire);
endinterface
`default_nettype wire

// ---- rtl/tsbg_trig_det.sv ----
// Purpose: Synchronises trigger pins and detects qualified edges
// Assumes: Pins asynchronous to aclk
// Notes: Software trigger bypasses edge qualification
`timescale 1ns/1ps
`default_nettype none
module tsbg_trig_det
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] trig_in,
	tsbg_trig_if.det tif
);
	import tsbg_pkg::*;
	logic [3:0] meta_r;
	logic [3:0] sync_r;
	logic [3:0] prev_r;
	logic sel_now;
	logic sel_prev;
	logic rise;
	logic fall;
	logic fire_r;
	// Two-stage synchroniser then history
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_r <= 4'h0;
			sync_r <= 4'h0;
			prev_r <= 4'h0;
		end
		else
		begin
			meta_r <= trig_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end
	// Selected input edges
	always_comb
	begin
		sel_now = 1'b0;
		sel_prev = 1'b0;
		if (tif.src != TSBG_SRC_SW)
		begin
			sel_now = sync_r[tif.src[1:0]]; // R1
			sel_prev = prev_r[tif.src[1:0]];
		end
	end
	assign rise = sel_now & ~sel_prev;
	assign fall = ~sel_now & sel_prev;
	// Event pulse by edge setting
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fire_r <= 1'b0;
		else if (tif.src == TSBG_SRC_SW)
			fire_r <= tif.sw_pulse; // R2
		else
		begin
			case (tif.edge_sel)
				TSBG_EDGE_RISE: fire_r <= rise; // R3
				TSBG_EDGE_FALL: fire_r <= fall; // R4
				TSBG_EDGE_BOTH: fire_r <= rise | fall; // R5
				default: fire_r <= 1'b0; // R6
			endcase
		end
	end
	assign tif.fire = fire_r;
endmodule
`default_nettype wire

// ---- rtl/tsbg_rate_div.sv ----
// Purpose: Produces the one-cycle sample-rate enable
// Assumes: Divisor 0 means every cycle
// Notes: Rate is aclk/(div+1); software rounds to nearest supported
`timescale 1ns/1ps
`default_nettype none
module tsbg_rate_div
#(
	parameter int W = 16
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] div,
	output logic tick
);
	logic [W-1:0] cnt_r;
	// Refuse divisor widths the counter cannot serve
	if (W < 1 || W > 32)
	begin
		$error("tsbg_rate_div width out of range");
	end
	// Down counter reloads with divisor
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_r <= '0;
		else if (cnt_r == '0 || cnt_r > div)
			cnt_r <= div; // R11
		else
			cnt_r <= cnt_r - 1'b1;
	end
	assign tick = (cnt_r == '0);
endmodule
`default_nettype wire

// ---- rtl/tsbg_gate.sv ----
// Purpose: Gates controller samples to host, continuous or triggered bursts
// Assumes: AXI4-Lite slave, one clock, synchronous active-low reset
// Notes: Sample taken on rate tick; output holds until host accepts
//  Write 0x0 control: bit0 controller on, bit1 transfer on, bit2 triggered
//  Write 0x0 control: bits 5:4 edge setting, bits 10:8 source
//  Edge settings: 0 none, 1 rising, 2 falling, 3 both
//  Sources: 0 to 3 trigger inputs one to four, 4 and up software
//  Write 0x4 burst length, 0 disables bursts
//  Write 0x8 rate divisor, one sample every divisor plus one cycles
//  Write 0xc bit0 one-shot software trigger
//  Read 0x0 status: bit2 output pending, bit1 in burst, bit0 enabled
//  Read 0x4 samples sent, 0x8 samples left in burst
//  Read 0xc and unaligned offsets answer with slave error
//  Unmapped write offsets answer with slave error
//  Write address and data taken in either order, one write at a time
//  Address and data readies stay low until the response is taken
//  Host stall skips a rate tick rather than queueing a sample
//  Clearing an enable or triggered mode aborts a running burst
// Contract
// R1: Source is input one to four or software
// R2: Software write fires trigger when software selected
// R3: Rising setting fires on low-to-high
// R4: Falling setting fires on high-to-low
// R5: Both setting fires on any transition
// R6: None setting ignores hardware edges
// R7: Each event forwards exactly burst-length samples
// R8: Triggered mode sends only after events
// R9: Untriggered mode sends continuously
// R10: Send nothing unless controller and transfer enabled
// R11: Samples produced at configured streaming rate
// R12: Events during a burst are ignored
//
// Chosen here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tsbg_map.svh"
module tsbg_gate
#(
	parameter int DW = 32,
	parameter int RW = 16
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [3:0] trig_in,
	input wire logic [DW-1:0] ctl_sample,
	output logic [DW-1:0] host_data,
	output logic host_valid,
	input wire logic host_ready
);
	import tsbg_pkg::*;
	typedef enum {TSBG_IDLE, TSBG_BURST} tsbg_state_t;
	tsbg_trig_if tif();
	logic [31:0] ctrl_r;
	logic [31:0] burst_r;
	logic [31:0] rate_r;
	logic sw_r;
	logic aw_hold_r;
	logic w_hold_r;
	logic [3:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic wr_go;
	logic [31:0] wmask;
	logic tick;
	tsbg_state_t state_r;
	logic [31:0] left_r;
	logic [DW-1:0] data_r;
	logic valid_r;
	logic enabled;
	logic allow;
	logic [31:0] sent_r;
	// Refuse sample widths wider than the bus word
	if (DW < 1 || DW > 32)
	begin
		$error("tsbg_gate sample width out of range");
	end
	// Refuse divisor widths wider than the rate register
	if (RW < 1 || RW > 32)
	begin
		$error("tsbg_gate rate width out of range");
	end
	// Write channels held independently, taken in either order
	assign awready = ~aw_hold_r & ~bvalid_r;
	assign wready = ~w_hold_r & ~bvalid_r;
	assign wr_go = aw_hold_r & w_hold_r & ~bvalid_r;
	assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 4'h0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_hold_r <= 1'b1;
				awaddr_r <= awaddr;
			end
			else if (wr_go)
				aw_hold_r <= 1'b0;
			if (wvalid && wready)
			begin
				w_hold_r <= 1'b1;
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			else if (wr_go)
				w_hold_r <= 1'b0;
		end
	end
	// Register writes and write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_r <= 32'h0;
			burst_r <= `TSBG_BURST_RST;
			rate_r <= `TSBG_RATE_RST;
			sw_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
		end
		else
		begin
			// Software trigger strobe lasts one cycle
			sw_r <= 1'b0;
			if (bvalid_r && bready)
				bvalid_r <= 1'b0;
			if (wr_go)
			begin
				bvalid_r <= 1'b1;
				bresp_r <= 2'h0;
				case (awaddr_r)
					`TSBG_OFF_CTRL: ctrl_r <= (ctrl_r & ~wmask) | (wdata_r & wmask);
					`TSBG_OFF_BURST: burst_r <= (burst_r & ~wmask) | (wdata_r & wmask);
					`TSBG_OFF_RATE: rate_r <= (rate_r & ~wmask) | (wdata_r & wmask);
					`TSBG_OFF_SWTRIG: sw_r <= wstrb_r[0] & wdata_r[0]; // R2
					default: bresp_r <= 2'h2;
				endcase
			end
		end
	end
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	// Read channel: status, sent count and samples left
	assign arready = ~rvalid_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= 2'h0;
		end
		else if (arvalid && arready)
		begin
			rvalid_r <= 1'b1;
			rresp_r <= 2'h0;
			case (araddr)
				`TSBG_OFF_STATUS: rdata_r <= {29'h0, valid_r, (state_r == TSBG_BURST),
					enabled};
				`TSBG_OFF_COUNT: rdata_r <= sent_r;
				`TSBG_OFF_LEFT: rdata_r <= left_r; // R7
				default:
				begin
					rdata_r <= 32'h0;
					rresp_r <= 2'h2;
				end
			endcase
		end
		else if (rvalid_r && rready)
			rvalid_r <= 1'b0;
	end
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	// Configuration to trigger detector
	always_comb
	begin
		tif.sw_pulse = sw_r;
		tif.edge_sel = tsbg_edge_t'(ctrl_r[`TSBG_LSB_EDGE +: 2]);
		if (ctrl_r[`TSBG_LSB_SRC +: 3] > 3'h4)
			tif.src = TSBG_SRC_SW;
		else
			tif.src = tsbg_src_t'(ctrl_r[`TSBG_LSB_SRC +: 3]); // R1
	end
	// Edge qualification of the selected trigger
	tsbg_trig_det u_det
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.trig_in(trig_in),
		.tif(tif)
	);
	// Streaming rate enable
	tsbg_rate_div #(.W(RW)) u_div
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.div(rate_r[RW-1:0]),
		.tick(tick)
	);
	// Controller and its transfer must both be on
	assign enabled = ctrl_r[`TSBG_BIT_CTL_EN] & ctrl_r[`TSBG_BIT_XFER_EN]; // R10
	// Burst sequencer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r <= TSBG_IDLE;
			left_r <= 32'h0;
		end
		else if (!enabled || !ctrl_r[`TSBG_BIT_TRIG_EN])
		begin
			state_r <= TSBG_IDLE;
			left_r <= 32'h0;
		end
		else
		begin
			case (state_r)
				TSBG_IDLE:
					if (tif.fire && burst_r != 32'h0)
					begin
						state_r <= TSBG_BURST; // R8
						left_r <= burst_r;
					end
				TSBG_BURST:
					// Further events ignored here
					if (allow)
					begin
						left_r <= left_r - 32'h1; // R12
						if (left_r == 32'h1)
							state_r <= TSBG_IDLE; // R7
					end
				default: state_r <= TSBG_IDLE;
			endcase
		end
	end
	// A sample is captured on the rate tick when the gate is open
	always_comb
	begin
		if (!enabled)
			allow = 1'b0; // R10
		else if (!ctrl_r[`TSBG_BIT_TRIG_EN])
			allow = tick & (~valid_r | host_ready); // R9
		else
			allow = tick & (state_r == TSBG_BURST) & (~valid_r | host_ready); // R8
	end
	// Output register to host
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			valid_r <= 1'b0;
			data_r <= '0;
			sent_r <= 32'h0;
		end
		else
		begin
			if (allow)
			begin
				valid_r <= 1'b1; // R11
				data_r <= ctl_sample;
				sent_r <= sent_r + 32'h1;
			end
			else if (host_ready)
				valid_r <= 1'b0;
		end
	end
	assign host_valid = valid_r;
	assign host_data = data_r;
endmodule
`default_nettype wire

// ---- test/tsbg_host_model.sv ----
// Purpose: Host sink for the sample stream
// Assumes: Accept when ready and valid meet at aclk
// Notes: Stall gives random back-pressure
`timescale 1ns/1ps
`default_nettype none
module tsbg_host_model
(
	input wire logic aclk,
	input wire logic stall,
	output logic host_ready
);
	// Random refusals while stalling
	initial host_ready = 1'b0;
	always @(posedge aclk)
		host_ready <= !stall || $urandom_range(1);
endmodule
`default_nettype wire

// ---- test/tsbg_gate_checker.sv ----
// Purpose: Port assertions for the burst gate
// Assumes: One clock, sync active-low reset
// Notes: Bound into tsbg_gate
`timescale 1ns/1ps
`default_nettype none
module tsbg_gate_checker
#(
	parameter int DW = 32
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awready,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [DW-1:0] ctl_sample,
	input wire logic [DW-1:0] host_data,
	input wire logic host_valid,
	input wire logic host_ready
);
	// Stream and bus relations
	default clocking @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	stream_hold_a: assert property (
		host_valid && !host_ready |=> host_valid && $stable(host_data))
		else $error("sample changed before accept");
	sample_src_a: assert property (
		$rose(host_valid) |-> host_data == $past(ctl_sample))
		else $error("sample not from controller");
	read_lat_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	read_block_a: assert property (rvalid |-> !arready)
		else $error("read taken while answer pending");
	read_done_a: assert property (rvalid && rready |=> !rvalid)
		else $error("read answer repeated");
	write_block_a: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	write_free_a: assert property ($fell(bvalid) |-> awready && wready)
		else $error("write channels stay closed");
	reset_idle_a: assert property (
		disable iff (1'b0) !aresetn |=> !host_valid && !bvalid && !rvalid)
		else $error("outputs busy after reset");
endmodule
bind tsbg_gate tsbg_gate_checker #(.DW(DW)) u_chk (.aclk(aclk), .aresetn(aresetn),
	.awready(awready), .wready(wready), .bvalid(bvalid), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .ctl_sample(ctl_sample),
	.host_data(host_data), .host_valid(host_valid), .host_ready(host_ready));
`default_nettype wire

// ---- test/testbench.sv ----
// Purpose: Self-checking bench for the burst gate
// Assumes: AXI4-Lite master, host model sink
// Notes: Watcher pairs each accepted sample with the oldest note
`timescale 1ns/1ps
`default_nettype none
`include "tsbg_map.svh"
module testbench;
	logic aclk = 0, aresetn = 0, stall = 1;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [3:0] awaddr = 0, araddr = 0, wstrb = 0, trig_in = 0;
	logic [31:0] wdata = 0, ctl_sample = 0, rd_d, v, rdata, host_data;
	logic awready, wready, bvalid, arready, rvalid, host_valid, host_ready;
	logic [1:0] bresp, rresp, rd_r;
	logic [31:0] exp_q[$];
	int mismatches = 0, tests_run = 0, b, n, got = 0;
	int ev[4] = '{0, 1, 1, 2};
	always #20 aclk = ~aclk;
	tsbg_gate dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .trig_in(trig_in), .ctl_sample(ctl_sample),
		.host_data(host_data), .host_valid(host_valid), .host_ready(host_ready));
	tsbg_host_model host (.aclk(aclk), .stall(stall), .host_ready(host_ready));
	task chk(string nm, logic [31:0] e, logic [31:0] g);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task w(int k);
		repeat (k) @(posedge aclk);
	endtask
	task wr(logic [3:0] a, logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do
		begin
			@(posedge aclk);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end
		while (bvalid !== 1'b1);
		chk("bresp", 2'b00, bresp);
		bready <= 0;
		w(1);
	endtask
	task rd(logic [3:0] a);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do
		begin
			@(posedge aclk);
			if (arready) arvalid <= 0;
		end
		while (rvalid !== 1'b1);
		rd_d = rdata;
		rd_r = rresp;
		rready <= 0;
		w(1);
	endtask
	task pulse(int s, int g);
		trig_in[s] <= 1;
		w(g);
		trig_in[s] <= 0;
		w(150);
	endtask
	task end_of_test();
		$display("Checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Spurious samples meet an inverted note
	always @(posedge aclk)
		if (host_valid === 1'b1 && host_ready === 1'b1)
		begin
			got++;
			chk("host_data", exp_q.size() ? exp_q.pop_front() : ~host_data, host_data);
		end
	// Main sequence
	initial
	begin
		void'($urandom(75));
		w(8);
		aresetn <= 1;
		for (int i = 1; i < 3; i++)
		begin
			wr(`TSBG_OFF_CTRL, i);
			w(100);
		end
		v = $urandom;
		ctl_sample <= v;
		stall <= 0;
		repeat (1000) exp_q.push_back(v);
		wr(`TSBG_OFF_RATE, 3);
		wr(`TSBG_OFF_CTRL, 3);
		w(100);
		wr(`TSBG_OFF_CTRL, 0);
		w(20);
		n = 1000 - exp_q.size();
		chk("rate", 1, n >= 24 && n <= 28);
		exp_q.delete();
		stall <= 1;
		for (int m = 0; m < 4; m++)
		begin
			b = $urandom_range(4, 1);
			v = $urandom;
			ctl_sample <= v;
			wr(`TSBG_OFF_BURST, b);
			wr(`TSBG_OFF_RATE, $urandom_range(2));
			wr(`TSBG_OFF_CTRL, 7 | m << `TSBG_LSB_EDGE | m << `TSBG_LSB_SRC);
			repeat (b * ev[m]) exp_q.push_back(v);
			pulse(m, 150);
			chk("left", 0, exp_q.size());
		end
		rd(`TSBG_OFF_LEFT);
		chk("left_reg", 0, rd_d);
		wr(`TSBG_OFF_BURST, 4);
		wr(`TSBG_OFF_RATE, 2);
		wr(`TSBG_OFF_CTRL, 7 | 3 << `TSBG_LSB_EDGE);
		repeat (4) exp_q.push_back(v);
		pulse(0, 3);
		chk("left", 0, exp_q.size());
		for (int s = 4; s >= 0; s -= 4)
		begin
			wr(`TSBG_OFF_CTRL, 7 | s << `TSBG_LSB_SRC);
			if (s) repeat (4) exp_q.push_back(v);
			wr(`TSBG_OFF_SWTRIG, 1);
			w(150);
			chk("left", 0, exp_q.size());
		end
		rd(`TSBG_OFF_SWTRIG);
		chk("rresp", 2'b10, rd_r);
		rd(`TSBG_OFF_COUNT);
		chk("count", got, rd_d);
		rd(`TSBG_OFF_STATUS);
		chk("status", 32'h1, rd_d);
		end_of_test();
	end
	// Watchdog
	initial
	begin
		w(20000);
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
